// ---- inc/fst_defs.vh ----
// Constants for the free running system tick block.
// Assumes inclusion by the core files only.
`ifndef FST_DEFS_VH
`define FST_DEFS_VH

`define FST_CLK_HZ        50000000
`define FST_XTAL_HZ       24000000
`define FST_TMR_HZ        16000000
`define FST_TICK_W        32
`define FST_TICK_RST      32'h00000000
`define FST_INIT_NS       1000
`define FST_INIT_CYC      ((`FST_INIT_NS * 50 + 999) / 1000)
// Fractional accumulator for a rate from the 50 MHz clock
`define FST_ACC_W         26
// Rates as accumulator increments in Hz, sized to the accumulator
`define FST_CLK_RATE      26'h2FAF080
`define FST_RATE_16       26'h0F42400
`define FST_RATE_24       26'h16E3600
`define FST_RATE_32       26'h1E84800
`define FST_RATE_48       26'h2DC6C00
// System clock selections
`define FST_SEL_W         3
`define FST_SEL_X16       3'h0
`define FST_SEL_X24       3'h1
`define FST_SEL_X32       3'h2
`define FST_SEL_X48       3'h3
`define FST_SEL_R24       3'h4
`define FST_SEL_R32       3'h5
`define FST_SEL_R48       3'h6
`define FST_SEL_RST       3'h1

`endif

// ---- core/fst_rate_gen.v ----
// Fractional rate generator: one-cycle enable pulses at RATE_HZ.
// Assumes RATE_HZ is below the 50 MHz core clock.
`timescale 1ns/100ps
`include "fst_defs.vh"

module fst_rate_gen (
    input  wire                   clk_i,     // Core clock
    input  wire                   sys_rst_i, // Async reset, high
    input  wire                   run_i,     // Allow pulses
    input  wire [`FST_ACC_W-1:0]  rate_i,    // Increment per cycle, Hz
    output reg                    tick_o     // One-cycle enable
);

    reg  [`FST_ACC_W-1:0] acc_q;
    wire [`FST_ACC_W:0]   sum_w;
    localparam [`FST_ACC_W:0] MOD = {1'b0, `FST_CLK_RATE};

    assign sum_w = {1'b0, acc_q} + {1'b0, rate_i};

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_q  <= {`FST_ACC_W{1'b0}};
            tick_o <= 1'b0;
        end else if (!run_i) begin
            acc_q  <= {`FST_ACC_W{1'b0}};
            tick_o <= 1'b0;
        end else if (sum_w >= MOD) begin
            acc_q  <= sum_w[`FST_ACC_W-1:0] - MOD[`FST_ACC_W-1:0];
            tick_o <= 1'b1;
        end else begin
            acc_q  <= sum_w[`FST_ACC_W-1:0];
            tick_o <= 1'b0;
        end
    end

endmodule

// ---- core/fst_snap.v ----
// Coherent snapshot register for the tick count.
// Assumes the count source and the reader share clk_i.
`timescale 1ns/100ps
`include "fst_defs.vh"

module fst_snap (
    input  wire                   clk_i,     // Core clock
    input  wire                   sys_rst_i, // Async reset, high
    input  wire                   rd_i,      // Read strobe
    input  wire [`FST_TICK_W-1:0] cnt_i,     // Live count
    output reg  [`FST_TICK_W-1:0] data_o,    // Held snapshot
    output reg                    vld_o      // Snapshot valid pulse
);

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_o <= `FST_TICK_RST;
            vld_o  <= 1'b0;
        end else begin
            vld_o <= rd_i;
            if (rd_i) begin
                data_o <= cnt_i; // [R14]
            end
        end
    end

endmodule

// ---- core/fst_top.v ----
// Free running 32-bit system tick with system clock selection.
// Assumes one 50 MHz core clock; 16 MHz and system rates are enables.
//
// Notes on behaviour
// [R01] Tick rate fixed 16 MHz, crystal times 2/3
// [R02] Tick rate independent of system clock choice
// [R03] Tick is read only; writes ignored
// [R04] Crystal doubled to 48, divided to rates
// [R05] RC 24 MHz path offers 24/32/48 rates
// [R06] 32-bit tick adds one per tick clock
// [R07] Tick wraps from all ones to zero
// [R08] Tick is zero when counting begins
// [R09] Counting starts once initialisation completes
// [R10] Tick never stalls while running
// [R11] Software subtracts ticks unsigned, 32 bit
// [R12] Software limits single intervals below 268 s
// [R13] Software prefers crystal system clock
// [R14] Reads return one coherent 32-bit snapshot
`timescale 1ns/100ps
`include "fst_defs.vh"

module fst_top (
    input  wire                   clk_i,       // Core clock, 50 MHz
    input  wire                   sys_rst_i,   // Async reset, high
    input  wire                   init_done_i, // System initialisation done
    input  wire [`FST_SEL_W-1:0]  clk_sel_i,   // System clock selection
    input  wire                   clk_sel_we_i,// Load clk_sel_i
    input  wire                   rd_i,        // Tick read strobe
    input  wire                   wr_i,        // Tick write strobe, ignored
    input  wire [`FST_TICK_W-1:0] wdata_i,     // Write data, ignored
    output reg  [`FST_TICK_W-1:0] tick_o,      // Read data snapshot
    output reg                    tick_vld_o,  // Read data valid pulse
    output reg                    running_o,   // Tick is counting
    output reg                    sys_en_o,    // System clock enable pulse
    output reg                    sys_rc_o,    // System clock from RC path
    output reg  [`FST_SEL_W-1:0]  clk_sel_o    // Active selection
);

    ////////////////////////////////////////////////////////////////////////
    // Start sequencing
    localparam [2:0] ST_RESET = 3'b001;
    localparam [2:0] ST_WAIT  = 3'b010;
    localparam [2:0] ST_RUN   = 3'b100;

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [7:0] dly_q;
    reg [7:0] dly_d;
    localparam integer INIT_CYC_I = `FST_INIT_CYC;
    localparam [7:0]   INIT_CYC   = INIT_CYC_I[7:0];

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                if (init_done_i) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (dly_q == INIT_CYC) begin
                    state_d = ST_RUN; // [R09]
                end
            end
            ST_RUN: begin
                state_d = ST_RUN; // [R10]
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    // Settle delay counts only while waiting, then saturates
    always @* begin
        dly_d = dly_q;
        if (state_q == ST_WAIT && dly_q != INIT_CYC) begin
            dly_d = dly_q + 8'h01; // [R09]
        end
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_RESET;
            dly_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            dly_q   <= dly_d;
        end
    end

    wire run_w = (state_q == ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Tick clock: fixed 16 MHz from crystal, never from clk_sel
    localparam [`FST_ACC_W-1:0] TMR_RATE = `FST_RATE_16;
    wire tmr_en_w;

    fst_rate_gen u_tmr_rate (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (run_w),
        .rate_i    (TMR_RATE),   // [R01] [R02]
        .tick_o    (tmr_en_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Tick counter
    reg [`FST_TICK_W-1:0] cnt_q;
    reg [`FST_TICK_W-1:0] cnt_d;

    // Held at zero until running, then one per tick enable
    always @* begin
        cnt_d = cnt_q;
        if (!run_w) begin
            cnt_d = `FST_TICK_RST; // [R08]
        end else if (tmr_en_w) begin
            cnt_d = cnt_q + 32'h00000001; // [R06] [R07]
        end
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= `FST_TICK_RST; // [R08]
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Write port has no path into cnt_q
    wire unused_wr_w = wr_i | (|wdata_i); // [R03]

    wire [`FST_TICK_W-1:0] snap_w;
    wire                   snap_vld_w;

    fst_snap u_snap (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .rd_i      (rd_i),
        .cnt_i     (cnt_q),
        .data_o    (snap_w),
        .vld_o     (snap_vld_w)
    );

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_o     <= `FST_TICK_RST;
            tick_vld_o <= 1'b0;
            running_o  <= 1'b0;
        end else begin
            tick_o     <= snap_w;
            tick_vld_o <= snap_vld_w;
            running_o  <= run_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System clock selection
    reg [`FST_SEL_W-1:0]   sel_q;
    reg [`FST_SEL_W-1:0]   sel_d;
    reg                    sel_ok;
    reg [`FST_ACC_W-1:0]   sys_rate;
    reg                    sys_rc;

    // Unused code refused, so the system enable never stops
    always @* begin
        sel_ok = 1'b0;
        case (clk_sel_i)
            `FST_SEL_X16: sel_ok = 1'b1;
            `FST_SEL_X24: sel_ok = 1'b1;
            `FST_SEL_X32: sel_ok = 1'b1;
            `FST_SEL_X48: sel_ok = 1'b1;
            `FST_SEL_R24: sel_ok = 1'b1;
            `FST_SEL_R32: sel_ok = 1'b1;
            `FST_SEL_R48: sel_ok = 1'b1;
            default:      sel_ok = 1'b0;
        endcase
    end

    always @* begin
        sel_d = sel_q;
        if (clk_sel_we_i && sel_ok) begin
            sel_d = clk_sel_i;
        end
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_q <= `FST_SEL_RST;
        end else begin
            sel_q <= sel_d;
        end
    end

    // Crystal: 24 MHz doubled, divided by 3, 2, 1.5, 1
    always @* begin
        sys_rc   = 1'b0;
        sys_rate = `FST_RATE_24;
        case (sel_q)
            `FST_SEL_X16: begin
                sys_rc   = 1'b0;
                sys_rate = `FST_RATE_16; // [R04]
            end
            `FST_SEL_X24: begin
                sys_rc   = 1'b0;
                sys_rate = `FST_RATE_24; // [R04]
            end
            `FST_SEL_X32: begin
                sys_rc   = 1'b0;
                sys_rate = `FST_RATE_32; // [R04]
            end
            `FST_SEL_X48: begin
                sys_rc   = 1'b0;
                sys_rate = `FST_RATE_48; // [R04]
            end
            `FST_SEL_R24: begin
                sys_rc   = 1'b1;
                sys_rate = `FST_RATE_24; // [R05]
            end
            `FST_SEL_R32: begin
                sys_rc   = 1'b1;
                sys_rate = `FST_RATE_32; // [R05]
            end
            `FST_SEL_R48: begin
                sys_rc   = 1'b1;
                sys_rate = `FST_RATE_48; // [R05]
            end
            default: begin
                sys_rc   = 1'b0;
                sys_rate = `FST_RATE_24;
            end
        endcase
    end

    wire sys_en_w;

    fst_rate_gen u_sys_rate (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .run_i     (1'b1),
        .rate_i    (sys_rate),
        .tick_o    (sys_en_w)
    );

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sys_en_o  <= 1'b0;
            sys_rc_o  <= 1'b0;
            clk_sel_o <= `FST_SEL_RST;
        end else begin
            sys_en_o  <= sys_en_w;
            sys_rc_o  <= sys_rc;
            clk_sel_o <= sel_q;
        end
    end

endmodule

// ---- tb/fst_chk.sv ----
// Port checker for the free running tick block.
// Assumes it is bound onto fst_top, one clock domain.
`timescale 1ns/100ps
module fst_chk (
    input wire logic        clk_i,        // Clock
    input wire logic        sys_rst_i,    // Reset
    input wire logic        rd_i,         // Read strobe
    input wire logic        clk_sel_we_i, // Select load
    input wire logic [2:0]  clk_sel_i,    // Select code
    input wire logic [31:0] tick_o,       // Snapshot
    input wire logic        tick_vld_o,   // Snapshot valid
    input wire logic        running_o,    // Counting
    input wire logic        sys_en_o,     // System enable
    input wire logic [2:0]  clk_sel_o     // Active select
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_rd; rd_i |-> ##2 tick_vld_o; endproperty
    a_rd: assert property (p_rd) else $error("read unanswered");
    property p_vld; tick_vld_o |-> $past(rd_i, 2); endproperty
    a_vld: assert property (p_vld) else $error("stray valid");
    property p_hold; $changed(tick_o) |-> tick_vld_o; endproperty
    a_hold: assert property (p_hold) else $error("snapshot moved");
    property p_run; running_o |=> running_o; endproperty
    a_run: assert property (p_run) else $error("count stalled");
    property p_zero; tick_vld_o && !running_o |-> tick_o == 32'h00000000; endproperty
    a_zero: assert property (p_zero) else $error("tick not zero");
    property p_sel; clk_sel_we_i && clk_sel_i != 3'h7 |-> ##2 clk_sel_o == $past(clk_sel_i, 2);
    endproperty
    a_sel: assert property (p_sel) else $error("select not loaded");
    property p_bad; clk_sel_we_i && clk_sel_i == 3'h7 && !$past(clk_sel_we_i)
        |-> ##2 $stable(clk_sel_o); endproperty
    a_bad: assert property (p_bad) else $error("bad select taken");
    property p_x48; clk_sel_o == 3'h3 && $past(clk_sel_o) == 3'h3 && !sys_en_o |=> sys_en_o;
    endproperty
    a_x48: assert property (p_x48) else $error("48 rate gap");
    c_run: cover property ($rose(running_o));
    c_rd: cover property (tick_vld_o && running_o);
    c_bad: cover property (clk_sel_we_i && clk_sel_i == 3'h7);
endmodule
////////////////////////////////////////
bind fst_top fst_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rd_i(rd_i),
    .clk_sel_we_i(clk_sel_we_i), .clk_sel_i(clk_sel_i), .tick_o(tick_o),
    .tick_vld_o(tick_vld_o), .running_o(running_o), .sys_en_o(sys_en_o),
    .clk_sel_o(clk_sel_o));

// ---- tb/tb_fst_top.sv ----
// Self-checking bench for the free running tick block.
// Assumes fst_top at 50 MHz with the fst_chk binding.
`timescale 1ns/100ps
module tb_fst_top;
    logic        clk_i = 0;
    logic        sys_rst_i = 1;
    logic        init_done_i = 0;
    logic [2:0]  clk_sel_i = 0;
    logic        clk_sel_we_i = 0;
    logic        rd_i = 0;
    logic        wr_i = 0;
    logic [31:0] wdata_i = 0;
    wire  [31:0] tick_o;
    wire         tick_vld_o, running_o, sys_en_o, sys_rc_o;
    wire  [2:0]  clk_sel_o;
    integer      failures = 0, n_tests = 0, seed = 90, cyc = 0;
    integer      i, k, n, e, c0, c1;
    logic [31:0] t0, t1;
    int          rt[7] = '{16, 24, 32, 48, 24, 32, 48};
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    fst_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .init_done_i(init_done_i),
        .clk_sel_i(clk_sel_i), .clk_sel_we_i(clk_sel_we_i), .rd_i(rd_i), .wr_i(wr_i),
        .wdata_i(wdata_i), .tick_o(tick_o), .tick_vld_o(tick_vld_o),
        .running_o(running_o), .sys_en_o(sys_en_o), .sys_rc_o(sys_rc_o),
        .clk_sel_o(clk_sel_o));
    ////////////////////////////////////////
    task chk(input string nm, input logic [63:0] x, g);
        n_tests++;
        if (x !== g) begin
            failures++;
            $display("[ERR] %s exp %0h got %0h", nm, x, g);
        end
    endtask
    // Elapsed units within one of the ideal rate over dc cycles
    function automatic logic ok_rate(input logic [31:0] d, input integer dc, r);
        longint x;
        x = longint'(d) * 50 - longint'(dc) * r;
        return x > -50 && x < 50;
    endfunction
    task rd_tick(output logic [31:0] v, output integer c);
        @(posedge clk_i) rd_i <= 1;
        c = cyc;
        @(posedge clk_i) rd_i <= 0;
        for (n = 0; n < 8 && tick_vld_o !== 1'b1; n++) @(negedge clk_i);
        chk("vld", 1, tick_vld_o);
        v = tick_o;
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #600000;
        failures++;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 0;
        repeat (100) @(posedge clk_i);
        chk("idle", 0, running_o);
        init_done_i <= 1;
        for (k = 0; k < 60 && running_o !== 1'b1; k++) @(negedge clk_i);
        chk("wait", 1, k >= 49 && k <= 54);
        rd_tick(t0, c0);
        chk("first", 1, t0 < 4);
        // Random writes and select changes between reads
        for (i = 0; i < 40; i++) begin
            k = (i < 2) ? 0 : $unsigned($random(seed)) % 300;
            repeat (k) begin
                @(posedge clk_i);
                {wr_i, clk_sel_we_i, clk_sel_i} <= 5'($random(seed));
                wdata_i <= $random(seed);
            end
            rd_tick(t1, c1);
            chk("rate", 1, ok_rate(t1 - t0, c1 - c0, 16));
            t0 = t1;
            c0 = c1;
        end
        @(posedge clk_i) wr_i <= 0;
        clk_sel_we_i <= 0;
        for (i = 0; i < 8; i++) begin
            @(posedge clk_i) clk_sel_we_i <= 1;
            clk_sel_i <= i[2:0];
            @(posedge clk_i) clk_sel_we_i <= 0;
            if (i < 7) e = i;
            repeat (4) @(posedge clk_i);
            k = 0;
            repeat (50) @(negedge clk_i) k += sys_en_o;
            chk("sel", e, clk_sel_o);
            chk("rc", e >= 4, sys_rc_o);
            chk("sysrate", 1, ok_rate(k, 50, rt[e]));
        end
        // Leave the system clock on the crystal path
        @(posedge clk_i) clk_sel_we_i <= 1;
        clk_sel_i <= 3'h1;
        @(posedge clk_i) clk_sel_we_i <= 0;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk("xtal", 1, clk_sel_o);
        chk("xrc", 0, sys_rc_o);
        rd_tick(t1, c1);
        chk("rate", 1, ok_rate(t1 - t0, c1 - c0, 16));
        report_and_stop;
    end
endmodule
